// ---- verilog/sebw_defines.vh ----
// constants of the serial eeprom bus write logic
`ifndef SEBW_DEFINES_VH
`define SEBW_DEFINES_VH
`define SEBW_TYPE_CODE      4'h5
`define SEBW_MEM_DEPTH      1024
`define SEBW_PAGE_SIZE      16
`define SEBW_ERASED_BYTE    8'hff
`define SEBW_WRITE_TIME_NS  5000000
`define SEBW_CLK_PERIOD_NS  40
`define SEBW_WRITE_CYCLES   (`SEBW_WRITE_TIME_NS / `SEBW_CLK_PERIOD_NS)
`define SEBW_PROG_STEP      1
`endif

// ---- verilog/sebw_sync.v ----
// two flip-flop synchroniser for one pin input
`timescale 1ns/10ps
`default_nettype none
module sebw_sync (
  input  wire clock,
  input  wire reset,
  input  wire din,
  output reg  dout
);
  reg meta_reg;

  // first stage only feeds the second stage
  always @(posedge clock) begin
    if (reset) begin
      meta_reg <= 1'b1;
      dout     <= 1'b1;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule // sebw_sync
`default_nettype wire

// ---- verilog/sebw_skid.v ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sebw_skid (
  input  wire        clock,
  input  wire        reset,
  input  wire        in_valid,
  input  wire [17:0] in_data,
  output wire        in_ready,
  output wire        out_valid,
  input  wire        out_ready,
  output wire [17:0] out_data
);
  reg [17:0] mem_reg [0:1];
  reg        wr_ptr_reg;
  reg        rd_ptr_reg;
  reg [1:0]  count_reg;

  assign in_ready  = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data  = mem_reg[rd_ptr_reg];

  // pointers and fill count; push and pop may share a cycle
  always @(posedge clock) begin
    if (reset) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end else begin
      if (in_valid && in_ready) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (out_valid && out_ready)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
    end
  end
endmodule // sebw_skid
`default_nettype wire

// ---- verilog/sebw_core.v ----
// serial eeprom target: bus framing, addressing, page write and read
`timescale 1ns/10ps
`default_nettype none
`include "sebw_defines.vh"
module sebw_core #(
  parameter WRITE_CYCLES = `SEBW_WRITE_CYCLES
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        address_strap_pin,
  input  wire        write_inhibit_pin,
  output reg         write_busy,
  output reg         prog_valid,
  output reg  [9:0]  prog_addr,
  output reg  [7:0]  prog_data,
  input  wire        prog_ready
);
  // timing notes for whoever picks this up next
  // every pin passes two flip-flops before any logic reads it
  // edge detect adds one more cycle, so bus events land three cycles late
  // the link clock must therefore stay well below one eighth of clock
  // a bus phase shorter than four cycles may be missed entirely
  // open-drain data: sda_out stays low, sda_oe high pulls the line down
  // sda_oe changes only after a falling link clock edge is seen
  // that keeps data steady while the link clock is high
  // start and stop both need the clock high on two samples in a row
  // a glitch shorter than one cycle on the clock counts as an edge if a sampling edge falls inside it
  //
  // state meaning
  // idle: wait for a start, release the data line
  // dev:  shift in the device byte, compare type code and strap
  // word: shift in the word address, loads the address counter
  // data: shift in write bytes into the page buffer
  // read: shift out one byte, most significant bit first
  // rack: the ninth clock of a read, sample the master's answer
  //
  // write path
  // bytes land in a sixteen entry page buffer, nothing touches the array
  // a stop after at least one byte starts the commit walk, unless inhibit was latched at the start
  // the commit walk pushes one byte a cycle into the two-entry buffer
  // the array side may stall; the buffer keeps every word meanwhile
  // the busy timer starts once the last byte has been pushed
  // trade-off: a stalled array lengthens busy rather than dropping bytes
  //
  // read path
  // the byte is fetched when the ack clock ends, in the same cycle that bit 7 is driven
  // the counter advances after the eighth bit, before the master's answer
  // a missing answer ends the read; the counter keeps its new value
  //
  // limitation: inhibit is taken once per frame, at the start
  // a pin change inside a write frame has no effect until the next start

  // bus engine states
  localparam ST_IDLE  = 3'd0;
  localparam ST_DEV   = 3'd1;
  localparam ST_WORD  = 3'd2;
  localparam ST_DATA  = 3'd3;
  localparam ST_READ  = 3'd4;
  localparam ST_RACK  = 3'd5;

  // synchronised copies of every pin
  wire scl_s;
  wire sda_s;
  wire strap_s;
  wire wp_s;
  sebw_sync u_sync_scl (.clock(clock), .reset(reset), .din(scl_in), .dout(scl_s));
  sebw_sync u_sync_sda (.clock(clock), .reset(reset), .din(sda_in), .dout(sda_s));
  sebw_sync u_sync_a2 (.clock(clock), .reset(reset), .din(address_strap_pin), .dout(strap_s));
  sebw_sync u_sync_wp (.clock(clock), .reset(reset), .din(write_inhibit_pin), .dout(wp_s));

  // delayed copies for edge detection; reset to the idle high level
  // so that no false edge follows reset
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg [2:0]  state_reg;
  reg [3:0]  bit_cnt_reg;
  reg [7:0]  shift_reg;
  reg        ack_phase_reg;
  reg        acked_reg;
  reg [9:0]  addr_reg;
  reg [3:0]  base_lo_reg;
  reg [4:0]  page_cnt_reg;
  reg        wp_latched_reg;
  reg        rd_wr_reg;
  reg [7:0]  page_mem [0:15];
  reg [7:0]  array_mem [0:`SEBW_MEM_DEPTH-1];
  reg [31:0] busy_cnt_reg;
  reg [4:0]  commit_cnt_reg;
  reg        committing_reg;
  reg [7:0]  rd_byte_reg;
  integer    i;

  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire busy      = committing_reg | (busy_cnt_reg != 32'd0);

  // buffer in front of the array write port
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [17:0] buf_out_data;
  wire        buf_in_valid = committing_reg;
  wire [9:0]  commit_addr  = {addr_reg[9:4], base_lo_reg + commit_cnt_reg[3:0]};
  sebw_skid u_skid (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (buf_in_valid),
    .in_data   ({commit_addr, page_mem[base_lo_reg + commit_cnt_reg[3:0]]}),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_ready (prog_ready),
    .out_data  (buf_out_data)
  );

  // array content before any write: erased
  initial begin
    for (i = 0; i < `SEBW_MEM_DEPTH; i = i + 1)
      array_mem[i] = `SEBW_ERASED_BYTE;
  end

  // array write port and programming output, fed from the buffer
  always @(posedge clock) begin
    if (reset) begin
      prog_valid <= 1'b0;
      prog_addr  <= 10'h000;
      prog_data  <= 8'h00;
    end else begin
      prog_valid <= buf_out_valid & prog_ready;
      if (buf_out_valid && prog_ready) begin
        array_mem[buf_out_data[17:8]] <= buf_out_data[7:0];
        prog_addr <= buf_out_data[17:8];
        prog_data <= buf_out_data[7:0];
      end
    end
  end

  // main bus engine; a stall by the array holds the busy window open
  always @(posedge clock) begin
    if (reset) begin
      scl_d_reg      <= 1'b1;
      sda_d_reg      <= 1'b1;
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      ack_phase_reg  <= 1'b0;
      acked_reg      <= 1'b0;
      addr_reg       <= 10'h000;
      base_lo_reg    <= 4'h0;
      page_cnt_reg   <= 5'd0;
      wp_latched_reg <= 1'b0;
      rd_wr_reg      <= 1'b0;
      busy_cnt_reg   <= 32'd0;
      commit_cnt_reg <= 5'd0;
      committing_reg <= 1'b0;
      rd_byte_reg    <= 8'h00;
      sda_out        <= 1'b0;
      sda_oe         <= 1'b0;
      write_busy     <= 1'b0;
    end else begin
      scl_d_reg  <= scl_s;
      sda_d_reg  <= sda_s;
      write_busy <= busy;
      // commit page buffer then run the timer
      if (committing_reg) begin
        if (buf_in_ready) begin
          if (commit_cnt_reg + 5'd1 == page_cnt_reg) begin
            committing_reg <= 1'b0;
            busy_cnt_reg   <= WRITE_CYCLES;
          end
          commit_cnt_reg <= commit_cnt_reg + 5'd1;
        end
      end else if (busy_cnt_reg != 32'd0) begin
        busy_cnt_reg <= busy_cnt_reg - 32'd1;
      end

      if (busy) begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end else if (start_det) begin
        state_reg     <= ST_DEV;
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        sda_oe        <= 1'b0;
        page_cnt_reg  <= 5'd0;
        wp_latched_reg <= wp_s;
      end else if (stop_det) begin
        sda_oe    <= 1'b0;
        state_reg <= ST_IDLE;
        if (state_reg == ST_DATA && page_cnt_reg != 5'd0 && !wp_latched_reg) begin
          committing_reg <= 1'b1;
          commit_cnt_reg <= 5'd0;
        end
      end else if (state_reg != ST_IDLE) begin
        // while sending, the rising clock must not advance the bit count
        if (scl_rise && !ack_phase_reg && state_reg != ST_READ) begin
          shift_reg   <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (scl_rise && ack_phase_reg) begin
          acked_reg <= ~sda_s;
        end else if (scl_fall) begin
          if (ack_phase_reg) begin
            // ninth clock ended
            ack_phase_reg <= 1'b0;
            bit_cnt_reg   <= 4'h0;
            sda_oe        <= 1'b0;
            if (state_reg == ST_RACK) begin
              if (acked_reg) begin
                state_reg <= ST_READ;
                rd_byte_reg <= array_mem[addr_reg];
                sda_oe    <= ~array_mem[addr_reg][7];
                bit_cnt_reg <= 4'h1;
              end else
                state_reg <= ST_IDLE;
            end else if (state_reg == ST_READ) begin
              rd_byte_reg <= array_mem[addr_reg];
              sda_oe      <= ~array_mem[addr_reg][7];
              bit_cnt_reg <= 4'h1;
            end
          end else if (state_reg == ST_READ) begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe        <= 1'b0;
              ack_phase_reg <= 1'b1;
              state_reg     <= ST_RACK;
              addr_reg      <= addr_reg + 10'h001;
            end else begin
              sda_oe      <= ~rd_byte_reg[7 - bit_cnt_reg[2:0]];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end else if (bit_cnt_reg == 4'h8) begin
            ack_phase_reg <= 1'b1;
            case (state_reg)
              ST_DEV: begin
                if (shift_reg[7:4] == `SEBW_TYPE_CODE && shift_reg[3] == strap_s) begin
                  sda_oe        <= 1'b1;
                  rd_wr_reg     <= shift_reg[0];
                  addr_reg[9:8] <= shift_reg[2:1];
                  state_reg     <= shift_reg[0] ? ST_READ : ST_WORD;
                  if (shift_reg[0])
                    rd_byte_reg <= array_mem[{shift_reg[2:1], addr_reg[7:0]}];
                end else
                  state_reg <= ST_IDLE;
              end
              ST_WORD: begin
                sda_oe        <= 1'b1;
                addr_reg[7:0] <= shift_reg;
                base_lo_reg   <= shift_reg[3:0];
                state_reg     <= ST_DATA;
              end
              ST_DATA: begin
                sda_oe <= ~wp_latched_reg;
                page_mem[addr_reg[3:0]] <= shift_reg;
                addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
                if (page_cnt_reg != 5'd16)
                  page_cnt_reg <= page_cnt_reg + 5'd1;
                else
                  base_lo_reg <= base_lo_reg + 4'h1;
              end
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
      end
      sda_out <= 1'b0;
    end
  end
endmodule // sebw_core
`default_nettype wire

// ---- bench/sebw_core_asserts.sv ----
// port assertions of the serial eeprom bus logic
`timescale 1ns/10ps
`default_nettype none
module sebw_core_asserts #(
  parameter WRITE_CYCLES = 20
) (
  input wire clock,
  input wire reset,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire write_inhibit_pin,
  input wire write_busy,
  input wire prog_valid
);
  int busy_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // length of the running busy stretch; stalls may stretch it a little
  always @(posedge clock) begin
    busy_cnt <= (reset || !write_busy) ? 0 : busy_cnt + 1;
  end
  open_drain_a: assert property (sda_oe |-> !sda_out) else $error("data line driven high");
  busy_quiet_a: assert property (write_busy |-> !sda_oe) else $error("acknowledge while busy");
  scl_low_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
  inhibit_a: assert property (write_inhibit_pin |-> !prog_valid) else $error("write while inhibited");
  busy_min_a: assert property ($rose(write_busy) |-> write_busy[*8]) else $error("busy too short");
  busy_end_a: assert property ($rose(write_busy) |-> ##[1:1000] !write_busy) else $error("busy stuck");
  busy_max_a: assert property (busy_cnt <= WRITE_CYCLES + 200) else $error("busy too long");
  reset_quiet_a: assert property ($fell(reset) |-> !sda_oe && !write_busy && !prog_valid) else $error("not idle");
  cover property ($rose(sda_oe));
  cover property (prog_valid);
  cover property ($fell(write_busy));
endmodule // sebw_core_asserts
bind sebw_core sebw_core_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.clock(clock), .reset(reset), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .write_inhibit_pin(write_inhibit_pin), .write_busy(write_busy),
  .prog_valid(prog_valid));
`default_nettype wire

// ---- bench/sebw_master.sv ----
// bus master model: drives the link clock and pulls the data line low
`timescale 1ns/10ps
`default_nettype none
module sebw_master (
  output logic scl,
  output logic sda_low,
  input  wire  sda
);
  // clock stands high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    #40 sda_low = 1'b0;
    #120 scl = 1'b1;
    #160 sda_low = 1'b1;
    #160 scl = 1'b0;
  endtask
  task automatic stop();
    #40 sda_low = 1'b1;
    #120 scl = 1'b1;
    #160 sda_low = 1'b0;
    #160;
  endtask
  // nine clocks; bit nine is the acknowledge, mack pulls it low for reads
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 0; i < 9; i++) begin
      #40 sda_low = (i < 8) ? !tx[7 - i] : mack;
      #120 scl = 1'b1;
      #80 if (i < 8) rx[7 - i] = sda;
      else ack = !sda;
      #80 scl = 1'b0;
    end
  endtask
endmodule // sebw_master
`default_nettype wire

// ---- bench/serial_eeprom_bus_write_logic_test.sv ----
// self-checking bench of the eeprom bus logic
`timescale 1ns/10ps
`default_nettype none
`include "sebw_defines.vh"
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin bad_count++; $display("Error %0t: got %h want %h", $time, g, w); end end
module serial_eeprom_bus_write_logic_test;
  logic       clock, reset, strap, inhibit, prog_ready, scl, m_low, ak;
  wire        sda_out, sda_oe, write_busy, prog_valid;
  wire  [9:0] prog_addr;
  wire  [7:0] prog_data;
  logic [7:0] r, exp_mem [0:1023];
  int         bad_count, tests_run, progs, cycles;
  wire        sda = !m_low && !(sda_oe && !sda_out);
  sebw_core #(.WRITE_CYCLES(300)) DUT (.clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_strap_pin(strap), .write_inhibit_pin(inhibit), .write_busy(write_busy),
    .prog_valid(prog_valid), .prog_addr(prog_addr), .prog_data(prog_data), .prog_ready(prog_ready));
  sebw_master m (.scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #20 clock = !clock;
  end
  // array port stalls at random; every committed byte must match the model
  always @(posedge clock) begin
    prog_ready <= #1 ($urandom_range(3) != 0);
    cycles++;
    if (!reset && prog_valid) begin
      progs++;
      `CHK(prog_data, exp_mem[prog_addr])
    end
    if (cycles == 60000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] dev(input logic [9:0] a, input logic rd);
    return {`SEBW_TYPE_CODE, strap, a[9:8], rd};
  endfunction
  task automatic addr(input logic [9:0] a);
    m.start();
    m.xfer(dev(a, 1'b0), 1'b0, r, ak);
    `CHK(ak, 1'b1)
    m.xfer(a[7:0], 1'b0, r, ak);
    `CHK(ak, 1'b1)
  endtask
  // poll with the read bit; on an answer read one byte, refuse more and stop
  task automatic poll(input logic busy);
    logic x;
    for (int t = 0; t < 12; t++) begin
      m.start();
      m.xfer(dev(10'h000, 1'b1), 1'b0, r, ak);
      if (t == 0 && busy) `CHK(ak, 1'b0)
      if (ak) m.xfer(8'hff, 1'b0, r, x);
      m.stop();
      if (ak) return;
    end
    `CHK(ak, 1'b1)
  endtask
  task automatic wr(input logic [9:0] a, input int n, input logic inh);
    logic [7:0] d;
    inhibit = inh;
    addr(a);
    for (int k = 0; k < n; k++) begin
      d = $urandom;
      m.xfer(d, 1'b0, r, ak);
      `CHK(ak, !inh)
      if (!inh) exp_mem[{a[9:4], a[3:0] + k[3:0]}] = d;
    end
    progs = 0;
    m.stop();
    poll(n > 0 && !inh);
    `CHK(progs, (n > 0 && !inh) ? (n > 16 ? 16 : n) : 0)
  endtask
  task automatic rd(input logic [9:0] a, input int n);
    addr(a);
    m.start();
    m.xfer(dev(a, 1'b1), 1'b0, r, ak);
    `CHK(ak, 1'b1)
    for (int k = 0; k < n; k++) begin
      m.xfer(8'hff, k < n - 1, r, ak);
      `CHK(r, exp_mem[a + k[9:0]])
    end
    m.stop();
  endtask
  initial begin
    void'($urandom(32'h59b1));
    reset = 1'b1;
    strap = $urandom;
    inhibit = 1'b0;
    prog_ready = 1'b1;
    for (int i = 0; i < 1024; i++) exp_mem[i] = `SEBW_ERASED_BYTE;
    repeat (4) @(posedge clock);
    #1 reset = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    // wrong strap bit, then wrong type code: both refused
    for (int i = 0; i < 2; i++) begin
      m.start();
      m.xfer(dev(10'h000, 1'b0) ^ (i ? 8'h80 : 8'h08), 1'b0, r, ak);
      `CHK(ak, 1'b0)
      m.stop();
    end
    wr(10'h3f5, 1, 1'b0);
    wr(10'h12c, 18, 1'b0); // more than a page wraps inside it
    wr(10'h200, 3, 1'b1);
    wr(10'h0a0, 0, 1'b0);
    repeat (3) wr(10'($urandom), $urandom_range(16, 1), 1'b0);
    rd(10'h3f5, 1);
    rd(10'h120, 16);
    rd(10'h3ff, 2);
    rd(10'h200, 3);
    final_report();
  end
endmodule // serial_eeprom_bus_write_logic_test
`default_nettype wire
